// >>> design/sleep_clock_gate_defs.vh
// Purpose: Offsets, field positions, reset values and codes for the
//          sleep-mode clock gating register block.
// Assumes: 32-bit APB data, 12-bit byte address inside the block.
// Notes:   Definitions only; included by its bare name.
`ifndef SLEEP_CLOCK_GATE_DEFS_VH
`define SLEEP_CLOCK_GATE_DEFS_VH

// =====================================================================
// Address map
`define SCG_ADDR_W        12
`define SCG_OFF_SLEEP     12'h110
`define SCG_OFF_STATUS    12'h114
`define SCG_OFF_FAULT     12'h118

// =====================================================================
// Sleep gating register fields
`define SCG_RESET         32'h0000_0040
`define SCG_FIXED_MASK    32'h0000_0040
`define SCG_BIT_WDOG      3
`define SCG_BIT_RATE_LO   8
`define SCG_BIT_RATE_HI   9
`define SCG_BIT_ADC       16
`define SCG_BIT_PWM       20

// =====================================================================
// Sample-rate codes
`define SCG_RATE_125K     2'h0
`define SCG_RATE_250K     2'h1
`define SCG_RATE_500K     2'h2

// =====================================================================
// Unit indices in the three-bit enable vectors
`define SCG_UNITS         3
`define SCG_UNIT_WDOG     0
`define SCG_UNIT_ADC      1
`define SCG_UNIT_PWM      2

// =====================================================================
// Status register layout
`define SCG_ST_EN_LO      0
`define SCG_ST_MODE_LO    4
`define SCG_ST_ACG        8

`endif

// >>> design/clock_gate_cell.v
// Purpose: Glitch-free gating of one unit clock.
// Assumes: EN comes from a flop clocked on the rising edge of CLK.
// Notes:   Enable is retimed on the falling edge, so the gated clock
//          never shows a shortened high pulse.
`timescale 1ns/1ps

module clock_gate_cell (
    input  wire CLK,
    input  wire RSTN,
    input  wire EN,
    output wire GCLK
);

    reg en_low_r;

    // =================================================================
    // Enable retime
    // Low phase sampling keeps a change off the high half of CLK
    always @(negedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            en_low_r <= 1'b0;
        end else begin
            en_low_r <= EN;
        end
    end

    assign GCLK = CLK & en_low_r;

endmodule

// >>> design/sleep_clock_gate.v
// Purpose: Sleep-mode clock gating register with APB access, unit clock
//          gates and bus-fault flags for accesses to gated units.
// Assumes: Mode requests, run and deep-sleep enables, auto gating select
//          and unit selects come from logic on CLK.
// Notes:   Zero wait states; unmapped addresses answer with PSLVERR.
// Contract
// - Set bit clocks unit, clear stops it
// - Access to gated unit raises bus fault
// - Enables reset cleared, units start disabled
// - Whole register reads 0x00000040 after reset
// - Register governs unit clocks in Sleep only
// - Sleep settings apply only with auto gating; ADC_RATE follows bits 9:8 regardless of mode and auto gating
// - Bit 16 enables ADC clock in Sleep
// - Bit 20 enables PWM clock in Sleep
// - Bit 3 enables watchdog clock in Sleep
// - Bits 9:8 select ADC sample rate
// - Reserved bits read-only, read as zero except bit 6, which reads as one
`timescale 1ns/1ps
`include "sleep_clock_gate_defs.vh"

module sleep_clock_gate #(
    parameter [1:0] MAX_RATE = `SCG_RATE_500K
) (
    input  wire                    CLK,
    input  wire                    RSTN,
    input  wire                    PSEL,
    input  wire                    PENABLE,
    input  wire                    PWRITE,
    input  wire [`SCG_ADDR_W-1:0]  PADDR,
    input  wire [31:0]             PWDATA,
    input  wire [3:0]              PSTRB,
    output wire [31:0]             PRDATA,
    output wire                    PREADY,
    output wire                    PSLVERR,
    input  wire                    SLEEP_REQ,
    input  wire                    DEEP_SLEEP_REQ,
    input  wire                    AUTO_CLOCK_GATING_SELECT,
    input  wire [`SCG_UNITS-1:0]   RUN_CLOCK_GATE_EN,
    input  wire [`SCG_UNITS-1:0]   DEEP_SLEEP_CLOCK_GATE_EN,
    input  wire [`SCG_UNITS-1:0]   UNIT_SEL,
    output wire [`SCG_UNITS-1:0]   UNIT_FAULT,
    output wire [`SCG_UNITS-1:0]   UNIT_CLK_EN,
    output wire                    WATCHDOG_CLK,
    output wire                    ADC_CLK,
    output wire                    PWM_CLK,
    output wire [1:0]              ADC_RATE
);

    // =================================================================
    // Power modes, one-hot
    localparam [2:0] MODE_RUN   = 3'h1;
    localparam [2:0] MODE_SLEEP = 3'h2;
    localparam [2:0] MODE_DEEP  = 3'h4;

    // =================================================================
    // Declarations
    reg                   watchdog_clock_enable_r;
    reg                   adc_en_r;
    reg                   pwm_en_r;
    reg  [1:0]            rate_r;
    reg  [2:0]            mode_r;
    reg  [2:0]            mode_nxt;
    reg  [`SCG_UNITS-1:0] gate_en_r;
    reg  [`SCG_UNITS-1:0] gate_en_nxt;
    reg  [`SCG_UNITS-1:0] fault_r;
    reg  [31:0]           prdata_r;
    reg  [31:0]           rd_word;

    wire                  setup_ph;
    wire                  access_ph;
    wire                  hit_sleep;
    wire                  hit_status;
    wire                  hit_fault;
    wire                  addr_ok;
    wire                  wr_sleep;
    wire                  wr_fault;
    wire [`SCG_UNITS-1:0] sleep_bits;
    wire [`SCG_UNITS-1:0] fault_hit;
    wire [`SCG_UNITS-1:0] gclk;
    wire [31:0]           sleep_word;
    wire [31:0]           status_word;
    wire [31:0]           fault_word;

    // =================================================================
    // Helpers
    // Hardware guard: a code above the device maximum is held at it
    function [1:0] clamp_rate;
        input [1:0] req;
        begin
            clamp_rate = (req > MAX_RATE) ? MAX_RATE : req;
        end
    endfunction

    // Auto gating decides whether a low-power register is honoured
    function [`SCG_UNITS-1:0] pick_en;
        input [`SCG_UNITS-1:0] low_pwr;
        input [`SCG_UNITS-1:0] run;
        input                  auto_clock_gating_select;
        begin
            pick_en = auto_clock_gating_select ? low_pwr : run;
        end
    endfunction

    // Place a field at a bit position in a zero word
    function [31:0] place;
        input [1:0] val;
        input integer pos;
        begin
            place = {30'h0000_0000, val} << pos;
        end
    endfunction

    // =================================================================
    // APB decode
    assign setup_ph   = PSEL & ~PENABLE;
    assign access_ph  = PSEL & PENABLE;
    assign hit_sleep  = (PADDR == `SCG_OFF_SLEEP);
    assign hit_status = (PADDR == `SCG_OFF_STATUS);
    assign hit_fault  = (PADDR == `SCG_OFF_FAULT);
    assign addr_ok    = hit_sleep | hit_status | hit_fault;
    assign wr_sleep   = access_ph & PWRITE & hit_sleep;
    assign wr_fault   = access_ph & PWRITE & hit_fault;

    // Never stalls, so the master sees one access cycle
    assign PREADY     = 1'b1;
    assign PSLVERR    = access_ph & ~addr_ok;
    assign PRDATA     = prdata_r;

    // =================================================================
    // Read words
    // reserved read zero, fixed bit 6 reads one
    assign sleep_word = `SCG_FIXED_MASK
        | place({1'b0, watchdog_clock_enable_r}, `SCG_BIT_WDOG)
        | place(rate_r, `SCG_BIT_RATE_LO)
        | place({1'b0, adc_en_r}, `SCG_BIT_ADC)
        | place({1'b0, pwm_en_r}, `SCG_BIT_PWM);

    assign status_word = {29'h0000_0000, gate_en_r}
        | ({29'h0000_0000, mode_r} << `SCG_ST_MODE_LO)
        | ({31'h0000_0000, AUTO_CLOCK_GATING_SELECT} << `SCG_ST_ACG);

    assign fault_word  = {29'h0000_0000, fault_r};

    always @* begin
        rd_word = 32'h0000_0000;
        if (hit_sleep) begin
            rd_word = sleep_word;
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_fault) begin
            rd_word = fault_word;
        end
    end

    // Read data is caught in the setup cycle so PRDATA is a flop
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph && !PWRITE) begin
            prdata_r <= rd_word;
        end
    end

    // =================================================================
    // Sleep gating register
    // enables reset cleared
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            watchdog_clock_enable_r <= 1'b0;
            adc_en_r                <= 1'b0;
            pwm_en_r                <= 1'b0;
            rate_r                  <= `SCG_RATE_125K;
        end else if (wr_sleep) begin
            if (PSTRB[`SCG_BIT_WDOG / 8]) begin
                watchdog_clock_enable_r <= PWDATA[`SCG_BIT_WDOG];
            end
            if (PSTRB[`SCG_BIT_RATE_LO / 8]) begin
                rate_r <= clamp_rate(
                    PWDATA[`SCG_BIT_RATE_HI:`SCG_BIT_RATE_LO]);
            end
            if (PSTRB[`SCG_BIT_ADC / 8]) begin
                adc_en_r <= PWDATA[`SCG_BIT_ADC];
            end
            if (PSTRB[`SCG_BIT_PWM / 8]) begin
                pwm_en_r <= PWDATA[`SCG_BIT_PWM];
            end
        end
    end

    assign sleep_bits[`SCG_UNIT_WDOG] = watchdog_clock_enable_r;
    assign sleep_bits[`SCG_UNIT_ADC]  = adc_en_r;
    assign sleep_bits[`SCG_UNIT_PWM]  = pwm_en_r;
    assign ADC_RATE                   = rate_r;

    // =================================================================
    // Power mode tracking
    // Deep sleep wins when both requests stand
    always @* begin
        case (mode_r)
            MODE_RUN, MODE_SLEEP, MODE_DEEP: begin
                if (DEEP_SLEEP_REQ) begin
                    mode_nxt = MODE_DEEP;
                end else if (SLEEP_REQ) begin
                    mode_nxt = MODE_SLEEP;
                end else begin
                    mode_nxt = MODE_RUN;
                end
            end
            default: begin
                mode_nxt = MODE_RUN;
            end
        endcase
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_r <= MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // =================================================================
    // Effective unit enables
    // sleep register in Sleep only
    always @* begin
        case (mode_r)
            MODE_RUN: begin
                gate_en_nxt = RUN_CLOCK_GATE_EN;
            end
            MODE_SLEEP: begin
                gate_en_nxt = pick_en(sleep_bits, RUN_CLOCK_GATE_EN,
                                      AUTO_CLOCK_GATING_SELECT);
            end
            MODE_DEEP: begin
                gate_en_nxt = pick_en(DEEP_SLEEP_CLOCK_GATE_EN,
                                      RUN_CLOCK_GATE_EN,
                                      AUTO_CLOCK_GATING_SELECT);
            end
            default: begin
                gate_en_nxt = {`SCG_UNITS{1'b0}};
            end
        endcase
    end

    // Registered so the gate cells see a clean rising-edge enable
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gate_en_r <= {`SCG_UNITS{1'b0}};
        end else begin
            gate_en_r <= gate_en_nxt;
        end
    end

    assign UNIT_CLK_EN = gate_en_r;

    // =================================================================
    // Unit clock gates
    // clock only when enabled
    genvar u;
    generate
        for (u = 0; u < `SCG_UNITS; u = u + 1) begin : g_gate
            clock_gate_cell u_gate (
                .CLK  (CLK),
                .RSTN (RSTN),
                .EN   (gate_en_r[u]),
                .GCLK (gclk[u])
            );
        end
    endgenerate

    assign WATCHDOG_CLK = gclk[`SCG_UNIT_WDOG];
    assign ADC_CLK      = gclk[`SCG_UNIT_ADC];
    assign PWM_CLK      = gclk[`SCG_UNIT_PWM];

    // =================================================================
    // Bus fault for gated units
    // fault on gated access
    assign fault_hit  = UNIT_SEL & ~gate_en_r;
    assign UNIT_FAULT = fault_hit;

    // Sticky record, write one to clear; a new fault beats the clear
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fault_r <= {`SCG_UNITS{1'b0}};
        end else if (wr_fault && PSTRB[0]) begin
            fault_r <= (fault_r & ~PWDATA[`SCG_UNITS-1:0]) | fault_hit;
        end else begin
            fault_r <= fault_r | fault_hit;
        end
    end

endmodule

// >>> tb/scg_chk.sv
// Purpose: Port-level assertions for the sleep clock gating block
// Assumes: Zero-wait APB slave, one clock domain
// Notes:   Bound from tb_top
`timescale 1ns/1ps
`include "sleep_clock_gate_defs.vh"
module scg_chk #(
    parameter [1:0] MAX_RATE = `SCG_RATE_500K
) (
    input wire                   CLK,
    input wire                   RSTN,
    input wire                   PSEL,
    input wire                   PENABLE,
    input wire                   PWRITE,
    input wire [`SCG_ADDR_W-1:0] PADDR,
    input wire [31:0]            PWDATA,
    input wire [3:0]             PSTRB,
    input wire [31:0]            PRDATA,
    input wire                   PSLVERR,
    input wire                   SLEEP_REQ,
    input wire                   DEEP_SLEEP_REQ,
    input wire                   AUTO_CLOCK_GATING_SELECT,
    input wire [2:0]             RUN_CLOCK_GATE_EN,
    input wire [2:0]             DEEP_SLEEP_CLOCK_GATE_EN,
    input wire [2:0]             UNIT_SEL,
    input wire [2:0]             UNIT_FAULT,
    input wire [2:0]             UNIT_CLK_EN,
    input wire [1:0]             ADC_RATE
);
    wire acc = PSEL && PENABLE;
    wire hit = PADDR == `SCG_OFF_SLEEP;
    wire runm = !SLEEP_REQ && !DEEP_SLEEP_REQ;
    wire auto = AUTO_CLOCK_GATING_SELECT;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // =================================================================
    // Bus side
    a_err_map: assert property (acc |-> PSLVERR == !(hit ||
        PADDR == `SCG_OFF_STATUS || PADDR == `SCG_OFF_FAULT))
        else $error("slave error flag wrong for address");
    a_err_noeffect: assert property (acc && PSLVERR |=> $stable(ADC_RATE))
        else $error("refused write changed the rate");
    a_read_mask: assert property (acc && !PWRITE && hit |->
        (PRDATA & ~32'h0011_0308) == 32'h0000_0040)
        else $error("fixed bits of sleep register read wrong");
    a_rate_write: assert property (acc && PWRITE && hit && PSTRB[1] |=>
        ADC_RATE == (($past(PWDATA[9:8]) > MAX_RATE) ? MAX_RATE
        : $past(PWDATA[9:8]))) else $error("rate field not written");
    a_rate_read: assert property (acc && !PWRITE && hit |->
        PRDATA[9:8] == ADC_RATE) else $error("rate readback wrong");
    // =================================================================
    // Gating side
    a_fault_gated: assert property (UNIT_FAULT == (UNIT_SEL & ~UNIT_CLK_EN))
        else $error("unit fault does not match gated select");
    a_run_enable: assert property ($past(RSTN) &&
        (($past(!auto) && $past(!auto, 2)) ||
        ($past(runm) && $past(runm, 2))) |->
        UNIT_CLK_EN == $past(RUN_CLOCK_GATE_EN))
        else $error("run enables not applied");
    a_deep_enable: assert property ($past(RSTN) &&
        $past(DEEP_SLEEP_REQ) &&
        $past(DEEP_SLEEP_REQ, 2) && $past(auto) && $past(auto, 2) |->
        UNIT_CLK_EN == $past(DEEP_SLEEP_CLOCK_GATE_EN))
        else $error("deep sleep enables not applied");
endmodule

// >>> tb/tb_top.sv
// Purpose: Directed register and gating tests for sleep_clock_gate
// Assumes: Zero-wait APB slave, MAX_RATE at its default
// Notes:   Inputs change by NBA just after the rising edge
`timescale 1ns/1ps
`include "sleep_clock_gate_defs.vh"
module tb_top;
    logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic        SLEEP_REQ, DEEP_SLEEP_REQ, AUTO_CLOCK_GATING_SELECT;
    logic        WATCHDOG_CLK, ADC_CLK, PWM_CLK;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0]  PSTRB;
    logic [2:0]  RUN_CLOCK_GATE_EN, DEEP_SLEEP_CLOCK_GATE_EN, UNIT_SEL;
    logic [2:0]  UNIT_FAULT, UNIT_CLK_EN;
    logic [1:0]  ADC_RATE;
    int          fail_count, checked, adc_n, pwm_n, a0, p0, wd_n, w0;
    sleep_clock_gate dut (
        .CLK                      (CLK),
        .RSTN                     (RSTN),
        .PSEL                     (PSEL),
        .PENABLE                  (PENABLE),
        .PWRITE                   (PWRITE),
        .PADDR                    (PADDR),
        .PWDATA                   (PWDATA),
        .PSTRB                    (PSTRB),
        .PRDATA                   (PRDATA),
        .PREADY                   (PREADY),
        .PSLVERR                  (PSLVERR),
        .SLEEP_REQ                (SLEEP_REQ),
        .DEEP_SLEEP_REQ           (DEEP_SLEEP_REQ),
        .AUTO_CLOCK_GATING_SELECT (AUTO_CLOCK_GATING_SELECT),
        .RUN_CLOCK_GATE_EN        (RUN_CLOCK_GATE_EN),
        .DEEP_SLEEP_CLOCK_GATE_EN (DEEP_SLEEP_CLOCK_GATE_EN),
        .UNIT_SEL                 (UNIT_SEL),
        .UNIT_FAULT               (UNIT_FAULT),
        .UNIT_CLK_EN              (UNIT_CLK_EN),
        .WATCHDOG_CLK             (WATCHDOG_CLK),
        .ADC_CLK                  (ADC_CLK),
        .PWM_CLK                  (PWM_CLK),
        .ADC_RATE                 (ADC_RATE)
    );
    initial begin
        CLK = 1'h0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge ADC_CLK) adc_n++;
    always @(posedge PWM_CLK) pwm_n++;
    always @(posedge WATCHDOG_CLK) wd_n++;
    // =================================================================
    // Tasks
    task automatic cmp(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'h1 && n < 64);
        if (n >= 64)
            fail_count++;
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLK);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] ex);
        apb(1'h0, a, 32'h0000_0000, 4'h0);
        cmp(nm, ex, rd);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // =================================================================
    // Tests
    initial begin
        {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
        {SLEEP_REQ, DEEP_SLEEP_REQ, AUTO_CLOCK_GATING_SELECT} = 3'h0;
        {RUN_CLOCK_GATE_EN, DEEP_SLEEP_CLOCK_GATE_EN, UNIT_SEL} = 9'h000;
        tick(8);
        RSTN <= 1'h1;
        tick(1);
        rdchk("sleep reg", 12'h110, 32'h0000_0040);
        cmp("rate", 32'h0000_0000, 32'(ADC_RATE));
        rdchk("status", 12'h114, 32'h0000_0010);
        $display("test reset done");
        apb(1'h1, 12'h110, 32'hFFFF_FFFF, 4'hF);
        rdchk("all ones", 12'h110, 32'h0011_0248);
        for (int r = 0; r < 3; r++) begin
            apb(1'h1, 12'h110, 32'(r) << 8, 4'h2);
            rdchk("rate code", 12'h110, 32'h0011_0048 | 32'(r) << 8);
            cmp("rate port", 32'(r), 32'(ADC_RATE));
        end
        apb(1'h1, 12'h110, 32'h0000_0300, 4'h2);
        rdchk("rate clamp", 12'h110, 32'h0011_0248);
        apb(1'h1, 12'h114, 32'h0000_0000, 4'hF);
        cmp("status write err", 32'h0000_0000, 32'(er));
        apb(1'h1, 12'h200, 32'h0000_0000, 4'hF);
        cmp("unmapped err", 32'h0000_0001, 32'(er));
        rdchk("unchanged", 12'h110, 32'h0011_0248);
        $display("test fields done");
        apb(1'h1, 12'h110, 32'h0010_0008, 4'hF);
        RUN_CLOCK_GATE_EN <= 3'h2;
        DEEP_SLEEP_CLOCK_GATE_EN <= 3'h1;
        AUTO_CLOCK_GATING_SELECT <= 1'h1;
        SLEEP_REQ <= 1'h1;
        tick(4);
        cmp("sleep en", 32'h0000_0005, 32'(UNIT_CLK_EN));
        a0 = adc_n;
        p0 = pwm_n;
        w0 = wd_n;
        tick(8);
        cmp("wdog clk runs", 32'h0000_0001, 32'(wd_n - w0 > 6));
        cmp("adc clk gated", 32'(a0), 32'(adc_n));
        cmp("pwm clk runs", 32'h0000_0001, 32'(pwm_n - p0 > 6));
        rdchk("status sleep", 12'h114, 32'h0000_0125);
        UNIT_SEL <= 3'h3;
        tick(3);
        cmp("fault", 32'h0000_0002, 32'(UNIT_FAULT));
        UNIT_SEL <= 3'h0;
        tick(1);
        rdchk("fault flags", 12'h118, 32'h0000_0002);
        apb(1'h1, 12'h118, 32'h0000_0007, 4'h1);
        rdchk("fault clear", 12'h118, 32'h0000_0000);
        AUTO_CLOCK_GATING_SELECT <= 1'h0;
        tick(4);
        cmp("no auto", 32'h0000_0002, 32'(UNIT_CLK_EN));
        AUTO_CLOCK_GATING_SELECT <= 1'h1;
        DEEP_SLEEP_REQ <= 1'h1;
        tick(4);
        cmp("deep", 32'h0000_0001, 32'(UNIT_CLK_EN));
        {SLEEP_REQ, DEEP_SLEEP_REQ} <= 2'h0;
        tick(4);
        cmp("run", 32'h0000_0002, 32'(UNIT_CLK_EN));
        $display("test gating done");
        RSTN <= 1'h0;
        tick(2);
        RSTN <= 1'h1;
        tick(1);
        rdchk("second reset", 12'h110, 32'h0000_0040);
        $display("test second reset done");
        report_and_stop();
    end
    initial begin
        #50000;
        fail_count++;
        report_and_stop();
    end
endmodule
bind sleep_clock_gate scg_chk #(.MAX_RATE(MAX_RATE)) chk (
    .CLK                      (CLK),
    .RSTN                     (RSTN),
    .PSEL                     (PSEL),
    .PENABLE                  (PENABLE),
    .PWRITE                   (PWRITE),
    .PADDR                    (PADDR),
    .PWDATA                   (PWDATA),
    .PSTRB                    (PSTRB),
    .PRDATA                   (PRDATA),
    .PSLVERR                  (PSLVERR),
    .SLEEP_REQ                (SLEEP_REQ),
    .DEEP_SLEEP_REQ           (DEEP_SLEEP_REQ),
    .AUTO_CLOCK_GATING_SELECT (AUTO_CLOCK_GATING_SELECT),
    .RUN_CLOCK_GATE_EN        (RUN_CLOCK_GATE_EN),
    .DEEP_SLEEP_CLOCK_GATE_EN (DEEP_SLEEP_CLOCK_GATE_EN),
    .UNIT_SEL                 (UNIT_SEL),
    .UNIT_FAULT               (UNIT_FAULT),
    .UNIT_CLK_EN              (UNIT_CLK_EN),
    .ADC_RATE                 (ADC_RATE)
);
